// *** core/lcc_map.svh ***
`ifndef LCC_MAP_SVH
`define LCC_MAP_SVH

// ----------------------------------------
// address ranges
// ----------------------------------------
`define LCC_X_MAX 6'h3F
`define LCC_PAGE_MAX 4'h9
`define LCC_PAGES 10
`define LCC_LINES 7'h40
`define LCC_RAM_WORDS 640

// ----------------------------------------
// command field positions
// ----------------------------------------
`define LCC_CMD_DISP_BIT 0
`define LCC_CMD_UP_BIT 0
`define LCC_CMD_SELY_BIT 1
`define LCC_CMD_FLAG_BIT 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define LCC_RST_SEL_Y 1'b1
`define LCC_RST_UP 1'b1
`define LCC_RST_DISP_ON 1'b0
`define LCC_RST_FLAG 1'b0
`define LCC_RST_X 6'h00
`define LCC_RST_PAGE 4'h0
`define LCC_RST_START 6'h00
`define LCC_RST_BYTE 8'h00

// ----------------------------------------
// timing counts
// ----------------------------------------
`define LCC_BUSY_PHI_EDGES 2'h2

`endif

// *** core/lcc_pkg.sv ***
package lcc_pkg;

  typedef enum logic [2:0] {
    LCC_CMD_NONE = 3'h0,
    LCC_CMD_DISP = 3'h1,
    LCC_CMD_CNT = 3'h2,
    LCC_CMD_TEST = 3'h3,
    LCC_CMD_START = 3'h4,
    LCC_CMD_X = 3'h5,
    LCC_CMD_PAGE = 3'h6
  } lcc_cmd_t;

  typedef enum logic [1:0] {
    LCC_IDLE = 2'b00,
    LCC_ACTIVE = 2'b01,
    LCC_COMMIT = 2'b11
  } lcc_bus_state_t;

  typedef struct packed {
    logic ce_n;
    logic wr_n;
    logic di;
  } lcc_bus_ctl_t;

  typedef struct packed {
    logic busy;
    logic zero6;
    logic disp_on;
    logic in_reset;
    logic zero3;
    logic flag_mode;
    logic sel_y;
    logic up;
  } lcc_status_t;

endpackage : lcc_pkg

// *** core/lcc_pin_sync.sv ***
`timescale 1ns/10ps

module lcc_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // ----------------------------------------
  // three stages, change taken when 2 and 3 agree
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk_in) begin
        if (reset_in) begin
          s1_reg[i] <= INIT[i];
          s2_reg[i] <= INIT[i];
          s3_reg[i] <= INIT[i];
          q_out[i] <= INIT[i];
        end else begin
          s1_reg[i] <= d_in[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          if (s2_reg[i] == s3_reg[i]) begin
            q_out[i] <= s3_reg[i];
          end
        end
      end
    end
  endgenerate

endmodule : lcc_pin_sync

// *** core/lcc_addr_step.sv ***
`timescale 1ns/10ps
`include "lcc_map.svh"

module lcc_addr_step (
  input wire logic [5:0] x_in,
  input wire logic [3:0] page_in,
  input wire logic sel_y_in,
  input wire logic up_in,
  output logic [5:0] x_out,
  output logic [3:0] page_out
);

  // ----------------------------------------
  // page step with wrap over 0..9
  // ----------------------------------------
  function automatic logic [3:0] page_move(input logic [3:0] p, input logic up);
    if (up) begin
      page_move = (p >= `LCC_PAGE_MAX) ? 4'h0 : 4'(p + 4'h1);
    end else begin
      page_move = (p == 4'h0) ? `LCC_PAGE_MAX : 4'(p - 4'h1);
    end
  endfunction : page_move

  always_comb begin
    x_out = x_in;
    page_out = page_in;
    if (sel_y_in) begin
      page_out = page_move(page_in, up_in);
      if (up_in && page_in == `LCC_PAGE_MAX) begin
        x_out = 6'(x_in + 6'h01);
      end else if (!up_in && page_in == 4'h0) begin
        x_out = 6'(x_in - 6'h01);
      end
    end else begin
      x_out = up_in ? 6'(x_in + 6'h01) : 6'(x_in - 6'h01);
      if (up_in && x_in == `LCC_X_MAX) begin
        page_out = page_move(page_in, 1'b1);
      end else if (!up_in && x_in == 6'h00) begin
        page_out = page_move(page_in, 1'b0);
      end
    end
  end

endmodule : lcc_addr_step

// *** core/lcc_ram_ctrl.sv ***
`timescale 1ns/10ps
`include "lcc_map.svh"

module lcc_ram_ctrl (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic rst_n_in,
  input wire logic phi_n_in,
  input wire logic ce_n_in,
  input wire logic wr_n_in,
  input wire logic di_in,
  input wire logic [7:0] host_data_bus_in,
  input wire logic [6:0] scan_row_in,
  input wire logic [6:0] duty_lines_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe_out,
  output logic [79:0] scan_data_out,
  output logic [5:0] start_line_out,
  output logic display_on_out
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic lcc_pkg::lcc_cmd_t decode_cmd(input logic [7:0] d);
    if (d[7:6] == 2'b11) decode_cmd = lcc_pkg::LCC_CMD_PAGE;
    else if (d[7:6] == 2'b10) decode_cmd = lcc_pkg::LCC_CMD_X;
    else if (d[7:6] == 2'b01) decode_cmd = lcc_pkg::LCC_CMD_START;
    else if (d[3]) decode_cmd = lcc_pkg::LCC_CMD_TEST;
    else if (d[2]) decode_cmd = lcc_pkg::LCC_CMD_CNT;
    else if (d[1]) decode_cmd = lcc_pkg::LCC_CMD_DISP;
    else decode_cmd = lcc_pkg::LCC_CMD_NONE;
  endfunction : decode_cmd

  function automatic logic [9:0] ram_index(input logic [5:0] x, input logic [3:0] p);
    ram_index = 10'(10'(x) * 10'd10 + 10'(p));
  endfunction : ram_index

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [4:0] pins_s;
  logic [7:0] db_s;
  lcc_pkg::lcc_bus_ctl_t ctl_s;
  logic rst_n_s;
  logic phi_n_s;

  lcc_pin_sync #(.W(5), .INIT(5'h1F)) u_ctl_sync (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .d_in({rst_n_in, phi_n_in, ce_n_in, wr_n_in, di_in}),
    .q_out(pins_s)
  );

  lcc_pin_sync #(.W(8), .INIT(8'h00)) u_db_sync (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .d_in(host_data_bus_in),
    .q_out(db_s)
  );

  assign ctl_s = pins_s[2:0];
  assign phi_n_s = pins_s[3];
  assign rst_n_s = pins_s[4];

  // ----------------------------------------
  // state and edges
  // ----------------------------------------
  lcc_pkg::lcc_bus_state_t state_reg;
  lcc_pkg::lcc_bus_ctl_t ctl_lat_reg;
  lcc_pkg::lcc_cmd_t cmd;
  lcc_pkg::lcc_status_t status;
  logic [7:0] data_lat_reg;
  logic ce_prev_reg;
  logic phi_prev_reg;
  logic ce_fall;
  logic ce_rise;
  logic phi_rise;
  logic dev_rst;
  logic in_reset_reg;
  logic busy_reg;
  logic [1:0] phi_cnt_reg;
  logic disp_on_reg;
  logic sel_y_reg;
  logic up_reg;
  logic flag_mode_reg;
  logic [5:0] start_reg;
  logic [5:0] top_line_reg;
  logic [5:0] x_reg;
  logic [3:0] page_reg;
  logic [5:0] x_step;
  logic [3:0] page_step;
  logic [7:0] out_reg;
  logic [7:0] disp_mem [`LCC_RAM_WORDS];
  logic [7:0] flag_mem [`LCC_PAGES];
  logic [7:0] scan_byte_reg [`LCC_PAGES];
  logic commit;
  logic is_status;
  logic accepted;
  logic is_cmd;
  logic is_wr;
  logic is_rd;
  logic page_ok;
  logic [6:0] scan_sum;
  logic flag_row;

  assign ce_fall = ce_prev_reg & ~ctl_s.ce_n;
  assign ce_rise = ~ce_prev_reg & ctl_s.ce_n;
  assign phi_rise = phi_prev_reg & ~phi_n_s;
  assign dev_rst = reset_in | ~rst_n_s;
  assign commit = state_reg == lcc_pkg::LCC_COMMIT;
  assign is_status = ctl_lat_reg.wr_n & ~ctl_lat_reg.di;
  assign accepted = commit & ~is_status & ~busy_reg;
  assign is_cmd = accepted & ~ctl_lat_reg.wr_n & ~ctl_lat_reg.di;
  assign is_wr = accepted & ~ctl_lat_reg.wr_n & ctl_lat_reg.di;
  assign is_rd = accepted & ctl_lat_reg.wr_n & ctl_lat_reg.di;
  assign cmd = decode_cmd(data_lat_reg);
  assign page_ok = page_reg <= `LCC_PAGE_MAX;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ce_prev_reg <= 1'b1;
      phi_prev_reg <= 1'b1;
      in_reset_reg <= 1'b1;
    end else begin
      ce_prev_reg <= ctl_s.ce_n;
      phi_prev_reg <= phi_n_s;
      in_reset_reg <= ~rst_n_s;
    end
  end

  // ----------------------------------------
  // host cycle sequencer
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_reg <= lcc_pkg::LCC_IDLE;
      ctl_lat_reg <= 3'b111;
      data_lat_reg <= `LCC_RST_BYTE;
    end else begin
      case (state_reg)
        lcc_pkg::LCC_IDLE: begin
          if (ce_fall) state_reg <= lcc_pkg::LCC_ACTIVE;
        end
        lcc_pkg::LCC_ACTIVE: begin
          if (ce_rise) begin
            state_reg <= lcc_pkg::LCC_COMMIT;
            ctl_lat_reg <= ctl_s;
            data_lat_reg <= db_s;
          end
        end
        lcc_pkg::LCC_COMMIT: state_reg <= lcc_pkg::LCC_IDLE;
        default: state_reg <= lcc_pkg::LCC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // busy flag
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (dev_rst) begin
      busy_reg <= 1'b0;
      phi_cnt_reg <= 2'h0;
    end else if (accepted) begin
      busy_reg <= 1'b1;
      phi_cnt_reg <= 2'h0;
    end else if (busy_reg && phi_rise) begin
      if (phi_cnt_reg == 2'(`LCC_BUSY_PHI_EDGES - 2'h1)) busy_reg <= 1'b0;
      phi_cnt_reg <= 2'(phi_cnt_reg + 2'h1);
    end
  end

  // ----------------------------------------
  // mode registers
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (dev_rst) begin
      disp_on_reg <= `LCC_RST_DISP_ON;
      sel_y_reg <= `LCC_RST_SEL_Y;
      up_reg <= `LCC_RST_UP;
      start_reg <= `LCC_RST_START;
    end else if (is_cmd) begin
      case (cmd)
        lcc_pkg::LCC_CMD_DISP: disp_on_reg <= data_lat_reg[`LCC_CMD_DISP_BIT];
        lcc_pkg::LCC_CMD_CNT: begin
          sel_y_reg <= data_lat_reg[`LCC_CMD_SELY_BIT];
          up_reg <= data_lat_reg[`LCC_CMD_UP_BIT];
        end
        lcc_pkg::LCC_CMD_START: start_reg <= data_lat_reg[5:0];
        lcc_pkg::LCC_CMD_TEST: start_reg <= start_reg;
        default: start_reg <= start_reg;
      endcase
    end
  end

  // ----------------------------------------
  // address counters
  // ----------------------------------------
  lcc_addr_step u_step (
    .x_in(x_reg),
    .page_in(page_reg),
    .sel_y_in(sel_y_reg),
    .up_in(up_reg),
    .x_out(x_step),
    .page_out(page_step)
  );

  always_ff @(posedge mclk_in) begin
    if (dev_rst) begin
      x_reg <= `LCC_RST_X;
      page_reg <= `LCC_RST_PAGE;
      flag_mode_reg <= `LCC_RST_FLAG;
    end else if (is_cmd && cmd == lcc_pkg::LCC_CMD_X) begin
      x_reg <= data_lat_reg[5:0];
    end else if (is_cmd && cmd == lcc_pkg::LCC_CMD_PAGE) begin
      page_reg <= data_lat_reg[3:0];
      flag_mode_reg <= data_lat_reg[`LCC_CMD_FLAG_BIT];
    end else if (is_wr || is_rd) begin
      x_reg <= x_step;
      page_reg <= page_step;
    end
  end

  // ----------------------------------------
  // RAM access
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (is_wr && page_ok) begin
      if (flag_mode_reg) flag_mem[page_reg] <= data_lat_reg;
      else disp_mem[ram_index(x_reg, page_reg)] <= data_lat_reg;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (dev_rst) begin
      out_reg <= `LCC_RST_BYTE;
    end else if (is_rd) begin
      if (!page_ok) out_reg <= `LCC_RST_BYTE;
      else if (flag_mode_reg) out_reg <= flag_mem[page_reg];
      else out_reg <= disp_mem[ram_index(x_reg, page_reg)];
    end
  end

  // ----------------------------------------
  // host data bus driver
  // ----------------------------------------
  always_comb begin
    status = '0;
    status.busy = busy_reg;
    status.disp_on = disp_on_reg;
    status.in_reset = in_reset_reg;
    status.flag_mode = flag_mode_reg;
    status.sel_y = sel_y_reg;
    status.up = up_reg;
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      host_data_bus_out <= `LCC_RST_BYTE;
      host_data_bus_oe_out <= 1'b0;
    end else if (state_reg == lcc_pkg::LCC_IDLE && ce_fall && ctl_s.wr_n) begin
      host_data_bus_oe_out <= 1'b1;
      host_data_bus_out <= ctl_s.di ? out_reg : status;
    end else if (ce_rise) begin
      host_data_bus_oe_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // scan side
  // ----------------------------------------
  assign scan_sum = 7'({1'b0, top_line_reg} + scan_row_in);
  assign flag_row = scan_row_in >= `LCC_LINES;

  always_ff @(posedge mclk_in) begin
    if (dev_rst) begin
      top_line_reg <= `LCC_RST_START;
    end else if (duty_lines_in < `LCC_LINES && {1'b0, start_reg} > duty_lines_in) begin
      top_line_reg <= duty_lines_in[5:0];
    end else begin
      top_line_reg <= start_reg;
    end
  end

  genvar p;
  generate
    for (p = 0; p < `LCC_PAGES; p++) begin : g_scan
      always_ff @(posedge mclk_in) begin
        if (dev_rst || !disp_on_reg) begin
          scan_byte_reg[p] <= `LCC_RST_BYTE;
        end else if (flag_row) begin
          scan_byte_reg[p] <= flag_mem[p];
        end else begin
          scan_byte_reg[p] <= disp_mem[ram_index(scan_sum[5:0], 4'(p))];
        end
      end
      assign scan_data_out[p*8 +: 8] = scan_byte_reg[p];
    end
  endgenerate

  assign start_line_out = start_reg;
  assign display_on_out = disp_on_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (dev_rst);

  busy_after_access_a: assert property (accepted |=> busy_reg [*2])
    else $error("busy not set after access");
  x_wrap_up_a: assert property ((is_wr || is_rd) && !sel_y_reg && up_reg && x_reg == 6'h3F
      |=> x_reg == 6'h00 && page_reg == (($past(page_reg) >= 4'h9) ? 4'h0
      : 4'($past(page_reg) + 4'h1)))
    else $error("x up wrap wrong");
  x_wrap_down_a: assert property ((is_wr || is_rd) && !sel_y_reg && !up_reg
      && x_reg == 6'h00 && page_reg == 4'h0 |=> x_reg == 6'h3F && page_reg == 4'h9)
    else $error("x down wrap wrong");
  page_wrap_up_a: assert property ((is_wr || is_rd) && sel_y_reg && up_reg
      && page_reg == 4'h9 |=> page_reg == 4'h0 && x_reg == 6'($past(x_reg) + 6'h01))
    else $error("page up wrap wrong");
  page_wrap_down_a: assert property ((is_wr || is_rd) && sel_y_reg && !up_reg
      && page_reg == 4'h0 |=> page_reg == 4'h9 && x_reg == 6'($past(x_reg) - 6'h01))
    else $error("page down wrap wrong");
  cmd_no_step_a: assert property (commit && (is_status || (is_cmd && cmd != lcc_pkg::LCC_CMD_X
      && cmd != lcc_pkg::LCC_CMD_PAGE)) |=> $stable(x_reg) && $stable(page_reg))
    else $error("address moved without data access");
  start_load_a: assert property (is_cmd && cmd == lcc_pkg::LCC_CMD_START
      |=> start_reg == $past(data_lat_reg[5:0]) ##1 start_line_out == start_reg)
    else $error("start line not loaded");
  page_load_a: assert property (is_cmd && cmd == lcc_pkg::LCC_CMD_PAGE
      |=> flag_mode_reg == $past(data_lat_reg[4]) && page_reg == $past(data_lat_reg[3:0]))
    else $error("page command not latched");
  stale_read_a: assert property (state_reg == lcc_pkg::LCC_IDLE && ce_fall && ctl_s.wr_n
      && ctl_s.di |=> host_data_bus_oe_out && host_data_bus_out == $past(out_reg))
    else $error("read did not return holding register");
  reset_mode_a: assert property (disable iff (reset_in) in_reset_reg |-> sel_y_reg && up_reg)
    else $error("reset counter mode wrong");

  write_seen_c: cover property (is_wr ##[1:1000] is_rd);
  flag_write_c: cover property (is_wr && flag_mode_reg);
  x_wrap_c: cover property ((is_wr || is_rd) && !sel_y_reg && x_reg == 6'h3F);
  busy_clear_c: cover property (busy_reg ##1 !busy_reg);

endmodule : lcc_ram_ctrl

// *** dv/lcc_host_model.sv ***
`timescale 1ns/10ps

// ----------------------------------------
// host processor bus model
// ----------------------------------------
module lcc_host_model (
  input wire logic mclk_in,
  input wire logic [7:0] bus_in,
  output logic ce_n_out,
  output logic wr_n_out,
  output logic di_out,
  output logic [7:0] bus_out,
  output logic bus_oe_out
);
  logic stuck = 1'b0;

  initial begin
    ce_n_out = 1'b1;
    wr_n_out = 1'b1;
    di_out = 1'b0;
    bus_out = 8'h00;
    bus_oe_out = 1'b0;
  end

  // ----------------------------------------
  // one access, ce low 8 clocks, then high 7 clocks
  // ----------------------------------------
  task automatic access(input logic wr, input logic di, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge mclk_in);
    wr_n_out = ~wr;
    di_out = di;
    bus_out = d;
    bus_oe_out = wr;
    ce_n_out = 1'b0;
    repeat (8) @(negedge mclk_in);
    q = bus_in;
    ce_n_out = 1'b1;
    repeat (7) @(negedge mclk_in);
    bus_oe_out = 1'b0;
  endtask : access

  // status polls until busy clears
  task automatic wait_ready();
    logic [7:0] s;
    s = 8'h80;
    for (int i = 0; i < 60 && s[7] !== 1'b0; i++) begin
      access(1'b0, 1'b0, 8'h00, s);
    end
    if (s[7] !== 1'b0) begin
      stuck = 1'b1;
    end
  endtask : wait_ready

  task automatic cmd(input logic [7:0] d);
    logic [7:0] q;
    if (d[7:3] == 5'h01) begin
      return;
    end
    access(1'b1, 1'b0, d, q);
    wait_ready();
  endtask : cmd

  task automatic wr(input logic [7:0] d);
    logic [7:0] q;
    access(1'b1, 1'b1, d, q);
    wait_ready();
  endtask : wr

  task automatic rd(output logic [7:0] q);
    access(1'b0, 1'b1, 8'h00, q);
    wait_ready();
  endtask : rd
endmodule : lcc_host_model

// *** dv/lcc_ram_ctrl_tb_top.sv ***
`timescale 1ns/10ps

module lcc_ram_ctrl_tb_top;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic rst_n_in = 1'b0;
  logic phi_n_in = 1'b1;
  logic [6:0] scan_row_in = 7'h00;
  logic [6:0] duty_lines_in = 7'h40;
  logic ce_n, wr_n, di, host_oe, dev_oe, disp_on;
  logic [7:0] host_d, dev_d, bus_w, hold_exp, q;
  logic [7:0] bus_last = 8'h00;
  logic [79:0] scan_data;
  logic [5:0] start_line, x, start, ax, lx;
  logic [3:0] pg, ap, lp;
  logic sel_y, up, flag;
  logic hv = 1'b0;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 32'h9B6B189A;
  logic [7:0] mem [10][64];
  logic [7:0] flag_mem [10];
  logic [5:0] xs [4] = '{6'h01, 6'h3E, 6'h00, 6'h3F};
  logic [3:0] ps [4] = '{4'h0, 4'h9, 4'h1, 4'h8};

  // ----------------------------------------
  // clocks and data bus wire
  // ----------------------------------------
  always #20 mclk_in = ~mclk_in;
  always #2000 phi_n_in = ~phi_n_in;
  always @(posedge mclk_in) bus_last <= bus_w;
  // undriven lines flip every cycle
  assign bus_w = dev_oe ? dev_d : (host_oe ? host_d : ~bus_last);

  lcc_ram_ctrl u_lcc_ram_ctrl (
    .mclk_in(mclk_in), .reset_in(reset_in), .rst_n_in(rst_n_in), .phi_n_in(phi_n_in),
    .ce_n_in(ce_n), .wr_n_in(wr_n), .di_in(di), .host_data_bus_in(bus_w),
    .scan_row_in(scan_row_in), .duty_lines_in(duty_lines_in), .host_data_bus_out(dev_d),
    .host_data_bus_oe_out(dev_oe), .scan_data_out(scan_data),
    .start_line_out(start_line), .display_on_out(disp_on)
  );

  lcc_host_model u_lcc_host_model (
    .mclk_in(mclk_in), .bus_in(bus_w), .ce_n_out(ce_n), .wr_n_out(wr_n), .di_out(di),
    .bus_out(host_d), .bus_oe_out(host_oe)
  );

  // ----------------------------------------
  // checking and expectations
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp || $isunknown(seen)) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 80000) begin
      fails++;
      finish_test();
    end
  end

  function automatic logic [7:0] exp_st();
    return {5'b00100, flag, sel_y, up};
  endfunction : exp_st

  function automatic void step();
    if (sel_y && up) begin
      x = (pg == 4'h9) ? x + 6'h01 : x;
      pg = (pg == 4'h9) ? 4'h0 : pg + 4'h1;
    end else if (sel_y) begin
      x = (pg == 4'h0) ? x - 6'h01 : x;
      pg = (pg == 4'h0) ? 4'h9 : pg - 4'h1;
    end else if (up) begin
      pg = (x == 6'h3F) ? ((pg == 4'h9) ? 4'h0 : pg + 4'h1) : pg;
      x = x + 6'h01;
    end else begin
      pg = (x == 6'h00) ? ((pg == 4'h0) ? 4'h9 : pg - 4'h1) : pg;
      x = x - 6'h01;
    end
  endfunction : step

  task automatic status_check(input logic [7:0] e);
    u_lcc_host_model.access(1'b0, 1'b0, 8'h00, q);
    check("status byte", q, e);
  endtask : status_check

  task automatic set_addr(input logic [5:0] nx, input logic [3:0] np);
    u_lcc_host_model.cmd({2'b10, nx});
    u_lcc_host_model.cmd({3'b110, flag, np});
    x = nx;
    pg = np;
  endtask : set_addr

  task automatic wr_data(input logic [7:0] d);
    u_lcc_host_model.wr(d);
    if (flag) flag_mem[pg] = d;
    else mem[pg][x] = d;
    lx = x;
    lp = pg;
    step();
  endtask : wr_data

  task automatic rd_check();
    u_lcc_host_model.rd(q);
    if (hv) begin
      check("read data", q, hold_exp);
    end
    hv = 1'b1;
    hold_exp = flag ? flag_mem[pg] : mem[pg][x];
    step();
  endtask : rd_check

  task automatic scan_check(input logic [6:0] row, input logic [3:0] p, input logic [7:0] e);
    @(negedge mclk_in);
    scan_row_in = row;
    repeat (6) @(negedge mclk_in);
    check("scan byte", scan_data[p*8+:8], e);
  endtask : scan_check

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge mclk_in);
    reset_in = 1'b0;
    repeat (6) @(negedge mclk_in);
    status_check(8'h13);
    rst_n_in = 1'b1;
    repeat (8) @(negedge mclk_in);
    status_check(8'h03);
    u_lcc_host_model.access(1'b1, 1'b0, 8'h03, q);
    u_lcc_host_model.access(1'b0, 1'b0, 8'h00, q);
    check("busy flag", {7'h00, q[7]}, 8'h01);
    u_lcc_host_model.wait_ready();
    check("display on", {7'h00, disp_on}, 8'h01);
    flag = 1'b0;
    for (int m = 0; m < 8; m++) begin
      sel_y = m[1];
      up = m[0];
      u_lcc_host_model.cmd({6'h01, sel_y, up});
      status_check(exp_st());
      if (m < 4) set_addr(xs[m], ps[m]);
      else set_addr(6'($random(seed)), 4'($unsigned($random(seed)) % 10));
      ax = x;
      ap = pg;
      for (int i = 0; i < 4; i++) begin
        wr_data(8'($random(seed)));
        if (i == 1) begin
          start = (m == 0) ? 6'h3F : 6'($random(seed));
          u_lcc_host_model.cmd({2'b01, start});
          check("start line", {2'b00, start_line}, {2'b00, start});
        end
      end
      scan_check({1'b0, 6'(lx - start)}, lp, mem[lp][lx]);
      if (m == 0) begin
        duty_lines_in = 7'h21;
        scan_check({1'b0, 6'(lx - 6'h21)}, lp, mem[lp][lx]);
        duty_lines_in = 7'h40;
      end
      set_addr(ax, ap);
      repeat (4) rd_check();
    end
    u_lcc_host_model.cmd(8'h07);
    sel_y = 1'b1;
    up = 1'b1;
    flag = 1'b1;
    set_addr(6'h3F, 4'h8);
    status_check(exp_st());
    repeat (2) wr_data(8'($random(seed)));
    scan_check(7'h40, 4'h8, flag_mem[8]);
    set_addr(6'h3F, 4'h8);
    repeat (2) rd_check();
    flag = 1'b0;
    set_addr(6'h3F, 4'h8);
    repeat (2) wr_data(8'($random(seed)));
    scan_check(7'h40, 4'h8, flag_mem[8]);
    set_addr(6'h3F, 4'h8);
    repeat (3) rd_check();
    set_addr(6'h05, 4'h2);
    u_lcc_host_model.access(1'b1, 1'b1, 8'h5A, q);
    mem[pg][x] = 8'h5A;
    step();
    u_lcc_host_model.access(1'b1, 1'b1, 8'hA5, q);
    u_lcc_host_model.wait_ready();
    wr_data(8'h3C);
    set_addr(6'h05, 4'h2);
    repeat (3) rd_check();
    check("host poll", {7'h00, u_lcc_host_model.stuck}, 8'h00);
    finish_test();
  end
endmodule : lcc_ram_ctrl_tb_top
